// ### lwc_core.sv
`timescale 1ns/1ps
// Functional notes
// R1 - LIN channel active only in normal mode, standby bit 0, battery above recovery.
// R2 - Active receive output high for recessive bus, low for dominant.
// R3 - Standby bit 1 puts the LIN channel in low power with wake detection.
// R4 - Standby or sleep with standby bit 0 powers the LIN channel off.
// R5 - LIN bus wake accepted only after dominant lasts the minimum wake time.
// R6 - Undriven LIN transmit input reads high through a pull-up.
// R7 - Transmit low beyond the time-out disables the transmitter, bus recessive.
// R8 - Rising edge on transmit input resets its dominant time-out timer.
// R9 - Each wake pin has its own edge field: falling, rising, both, off.
// R10 - Enabled wake pin event in standby or normal sets a wake interrupt.
// R11 - Local wake event in sleep wakes the chip into standby.
// R12 - Wake level flags valid only while some wake edge field is nonzero.
// R13 - Sample-enable 1 samples wake pin on bias rising edge, else continuously.
// R14 - Bias sampling period is 16 ms or 64 ms by one control bit.
// R15 - Open-drain interrupt output low while any status bit pends.
// R16 - Host clears a status bit by writing 1; only those bits clear.
// R17 - Clearing bus wake status bits leaves the pending wake-up set.
// R18 - Pending wake cleared in normal mode while its standby bit is 0.
// R19 - Cyclic interrupt enabled on watchdog time-out entry, standby or normal, disable low.
// R20 - Cyclic status set on each watchdog overflow in time-out mode.
// R21 - Overtemp in normal or standby: reset low, limp on, supplies and transmitters off.
// R22 - Overtemp clearing moves the chip to standby.
// R23 - Mode field 00 standby with main supply on, 01 sleep with both off.
// R24 - Mode field 10 keeps the CAN supply off, 11 turns it on.
// R25 - Analog indications pass a two-stage synchroniser before use.
module lwc_core
	import lwc_pkg::*;
#(
	parameter int TX_TO_CYCLES = TX_DOM_TO_CYC,
	parameter int MS_CYCLES    = MS_CYC
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire lwc_pins_t         pins_in,
	input  wire logic              wd_timeout_mode,
	input  wire logic              wd_overflow,
	output logic      [1:0]        lin_rxd,
	output logic      [1:0]        lin_tx_dom,
	output logic      [1:0]        lin_active,
	output logic      [1:0]        lin_lowpower,
	output logic                   can_tx_en,
	output logic                   v1_en,
	output logic                   v2_en,
	output logic                   limp_home,
	output logic                   wake_bias_out,
	output logic                   irq_out_n_o,
	output logic                   irq_out_n_oe,
	output logic                   system_reset_out_n_o,
	output logic                   system_reset_out_n_oe
);

	generate
		if (TX_TO_CYCLES < 1 || TX_TO_CYCLES >= (1 << 24) || MS_CYCLES < 1
			|| MS_CYCLES >= (1 << 20))
		begin : g_bad_param
			$error("lwc_core: counter parameter out of range");
		end
	endgenerate

	lwc_pins_t          sync1_r;
	lwc_pins_t          sync2_r;
	lwc_state_t         state_r;
	logic [1:0]         mode_r;
	logic               bias_sel_r;
	logic [DATA_W-1:0]  ictl_r;
	logic [IRQ_N-1:0]   stat_r;
	logic [2:0]         pend_r;
	logic [1:0]         txd_q_r;
	logic [23:0]        tx_cnt_r [2];
	logic [1:0]         tx_off_r;
	logic [15:0]        wk_cnt_r [2];
	logic [1:0]         lin_wake_hit;
	logic               can_q_r;
	logic               can_hit;
	logic [19:0]        ms_cnt_r;
	logic [6:0]         bias_cnt_r;
	logic               bias_q_r;
	logic               bias_rise;
	logic [1:0]         samp_r;
	logic [1:0]         samp_q_r;
	logic [1:0]         pin_evt;
	logic               wd_mode_q_r;
	logic               ci_en_r;
	logic               any_wake;
	logic [1:0]         stb;
	logic [1:0]         wic [2];
	logic [1:0]         wse;
	logic               mode_wr;
	logic               stat_wr;
	logic               awake;
	logic [IRQ_N-1:0]   stat_set;

	function automatic logic edge_hit(input logic [1:0] cfg, input logic prev, input logic cur);
		edge_hit = ((cfg == WIC_FALL || cfg == WIC_BOTH) && prev && !cur)
			|| ((cfg == WIC_RISE || cfg == WIC_BOTH) && !prev && cur);
	endfunction : edge_hit

	function automatic lwc_state_t mode_state(input logic [1:0] m);
		case (m)
			MODE_STBY:  mode_state = ST_STBY;
			MODE_SLEEP: mode_state = ST_SLEEP;
			default:    mode_state = ST_NORM;
		endcase
	endfunction : mode_state

	assign stb = {ictl_r[LIN2_STB_BIT], ictl_r[LIN1_STB_BIT]};
	assign wic[0] = ictl_r[FIRST_WAKE_EDGE_CFG_LSB +: 2];
	assign wic[1] = ictl_r[SECOND_WAKE_EDGE_CFG_LSB +: 2];
	assign wse = {ictl_r[SECOND_WAKE_SAMPLE_ENABLE_BIT], ictl_r[FIRST_WAKE_SAMPLE_ENABLE_BIT]};
	assign awake = (state_r == ST_STBY) || (state_r == ST_NORM);
	assign mode_wr = reg_wr && reg_addr == MODE_CTRL_OFS;
	assign stat_wr = reg_wr && reg_addr == INT_STAT_OFS;

	// R25 two-stage sync
	// The idle transmit pins reset high so a floating line reads recessive.
	// R6 pull-up default
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_r <= PINS_RST;
			sync2_r <= PINS_RST;
		end
		else
		begin
			sync1_r <= pins_in;
			sync2_r <= sync1_r;
		end
	end

	// R21 overtemp entry
	// R22 overtemp exit
	// R11 sleep wake-up
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= ST_STBY;
		else
		begin
			case (state_r)
				ST_STBY, ST_NORM:
					if (sync2_r.ot)
						state_r <= ST_OT;
					else if (mode_wr)
						state_r <= mode_state(reg_wdata[MODE_LSB +: 2]);
				ST_SLEEP:
					if (any_wake)
						state_r <= ST_STBY;
				ST_OT:
					if (!sync2_r.ot)
						state_r <= ST_STBY;
				default:
					state_r <= ST_STBY;
			endcase
		end
	end

	// R23 mode field
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode_r <= MODE_CTRL_RST[MODE_LSB +: 2];
			bias_sel_r <= MODE_CTRL_RST[BIAS_SEL_BIT];
		end
		else
		begin
			if (mode_wr)
				bias_sel_r <= reg_wdata[BIAS_SEL_BIT];
			if (awake && !sync2_r.ot && mode_wr)
				mode_r <= reg_wdata[MODE_LSB +: 2];
			else if ((state_r == ST_SLEEP && any_wake) || (awake && sync2_r.ot))
				mode_r <= MODE_STBY;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ictl_r <= INT_CTRL_RST;
		else if (reg_wr && reg_addr == INT_CTRL_OFS)
			ictl_r <= reg_wdata & 16'h01FF;
	end

	// Supplies and transceiver modes are registered so they never glitch.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lin_active <= 2'h0;
			lin_lowpower <= 2'h0;
			lin_rxd <= 2'h3;
			lin_tx_dom <= 2'h0;
			can_tx_en <= 1'b0;
			v1_en <= 1'b0;
			v2_en <= 1'b0;
			limp_home <= 1'b0;
			system_reset_out_n_oe <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				// R1 active condition
				lin_active[i] <= state_r == ST_NORM && !stb[i] && !sync2_r.bat_uv;
				// R3 low power
				// R4 off otherwise
				lin_lowpower[i] <= stb[i] && state_r != ST_OT;
				// R2 receive polarity
				lin_rxd[i] <= lin_active[i] ? !sync2_r.lin_dom[i] : 1'b1;
				// R7 transmitter disable
				lin_tx_dom[i] <= lin_active[i] && !txd_q_r[i] && !tx_off_r[i];
			end
			can_tx_en <= state_r == ST_NORM && !ictl_r[CAN_STB_BIT];
			// R24 CAN supply
			v2_en <= state_r == ST_NORM && mode_r == MODE_NORM_V2ON;
			v1_en <= awake;
			limp_home <= state_r == ST_OT;
			system_reset_out_n_oe <= state_r == ST_OT;
		end
	end

	assign system_reset_out_n_o = 1'b0;

	// R8 timer restart
	// R7 dominant time-out
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			txd_q_r <= 2'h3;
			tx_off_r <= 2'h0;
			tx_cnt_r[0] <= 24'h000000;
			tx_cnt_r[1] <= 24'h000000;
		end
		else
		begin
			txd_q_r <= sync2_r.txd;
			for (int i = 0; i < 2; i++)
			begin
				if (sync2_r.txd[i])
				begin
					tx_cnt_r[i] <= 24'h000000;
					tx_off_r[i] <= 1'b0;
				end
				else if (tx_cnt_r[i] >= 24'(TX_TO_CYCLES))
					tx_off_r[i] <= 1'b1;
				else
					tx_cnt_r[i] <= tx_cnt_r[i] + 24'h000001;
			end
		end
	end

	// R5 wake filter
	// A stretch of dominant counts once, so a stuck bus raises one wake only.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wk_cnt_r[0] <= 16'h0000;
			wk_cnt_r[1] <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (!lin_lowpower[i] || !sync2_r.lin_dom[i])
					wk_cnt_r[i] <= 16'h0000;
				else if (wk_cnt_r[i] < 16'(LIN_WAKE_CYC))
					wk_cnt_r[i] <= wk_cnt_r[i] + 16'h0001;
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < 2; i++)
			lin_wake_hit[i] = lin_lowpower[i] && sync2_r.lin_dom[i]
				&& wk_cnt_r[i] == 16'(LIN_WAKE_CYC - 1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			can_q_r <= 1'b0;
		else
			can_q_r <= sync2_r.can_wake;
	end

	assign can_hit = ictl_r[CAN_STB_BIT] && sync2_r.can_wake && !can_q_r;

	// R14 bias period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ms_cnt_r <= 20'h00000;
			bias_cnt_r <= 7'h00;
			bias_q_r <= 1'b0;
			wake_bias_out <= 1'b0;
		end
		else
		begin
			bias_q_r <= wake_bias_out;
			if (ms_cnt_r >= 20'(MS_CYCLES - 1))
			begin
				ms_cnt_r <= 20'h00000;
				if (bias_cnt_r >= 7'((bias_sel_r ? BIAS_LONG_MS : BIAS_SHORT_MS) - 1))
					bias_cnt_r <= 7'h00;
				else
					bias_cnt_r <= bias_cnt_r + 7'h01;
			end
			else
				ms_cnt_r <= ms_cnt_r + 20'h00001;
			wake_bias_out <= (|wse) && bias_cnt_r < 7'(BIAS_ON_MS);
		end
	end

	assign bias_rise = wake_bias_out && !bias_q_r;

	// R13 sampling choice
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			samp_r <= 2'h0;
			samp_q_r <= 2'h0;
		end
		else
		begin
			samp_q_r <= samp_r;
			for (int i = 0; i < 2; i++)
				if (!wse[i] || bias_rise)
					samp_r[i] <= sync2_r.wake_pin[i];
		end
	end

	// R9 edge selection
	always_comb
	begin
		for (int i = 0; i < 2; i++)
			pin_evt[i] = edge_hit(wic[i], samp_q_r[i], samp_r[i]);
	end

	assign any_wake = (|pin_evt) || (|lin_wake_hit) || can_hit;

	// R19 cyclic enable
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wd_mode_q_r <= 1'b0;
			ci_en_r <= 1'b0;
		end
		else
		begin
			wd_mode_q_r <= wd_timeout_mode;
			if (!wd_timeout_mode || sync2_r.wd_off)
				ci_en_r <= 1'b0;
			else if (!wd_mode_q_r && awake)
				ci_en_r <= 1'b1;
		end
	end

	always_comb
	begin
		stat_set = '0;
		// R10 pin wake interrupt
		stat_set[IRQ_PIN1_WAKE] = pin_evt[0] && state_r != ST_OT;
		stat_set[IRQ_PIN2_WAKE] = pin_evt[1] && state_r != ST_OT;
		stat_set[IRQ_LIN1_WAKE] = lin_wake_hit[0];
		stat_set[IRQ_LIN2_WAKE] = lin_wake_hit[1];
		stat_set[IRQ_CAN_WAKE] = can_hit;
		// R20 cyclic status
		stat_set[IRQ_CYCLIC] = ci_en_r && wd_timeout_mode && wd_overflow;
	end

	// R16 write one clears
	// A set in the same cycle as its clear wins, so no event is lost.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stat_r <= '0;
		else
			stat_r <= (stat_r & ~(stat_wr ? reg_wdata[IRQ_N-1:0] : '0)) | stat_set;
	end

	// R17 pending survives clear
	// R18 pending cleared
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pend_r <= 3'h0;
		else
		begin
			for (int i = 0; i < 2; i++)
				if (lin_wake_hit[i])
					pend_r[i] <= 1'b1;
				else if (state_r == ST_NORM && !stb[i])
					pend_r[i] <= 1'b0;
			if (can_hit)
				pend_r[2] <= 1'b1;
			else if (state_r == ST_NORM && !ictl_r[CAN_STB_BIT])
				pend_r[2] <= 1'b0;
		end
	end

	// R15 open-drain request
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_out_n_oe <= 1'b0;
		else
			irq_out_n_oe <= |stat_r;
	end

	assign irq_out_n_o = 1'b0;

	// R12 level flag gating
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			case (reg_addr)
				MODE_CTRL_OFS: reg_rdata <= {13'h0000, bias_sel_r, mode_r};
				INT_CTRL_OFS:  reg_rdata <= ictl_r;
				INT_STAT_OFS:  reg_rdata <= {10'h000, stat_r};
				WD_STATE_OFS:  reg_rdata <= {3'h0, pend_r, tx_off_r, lin_active,
					state_r == ST_OT, ((wic[0] != WIC_OFF || wic[1] != WIC_OFF) ? samp_r : 2'h0),
					ci_en_r, mode_r};
				default:       reg_rdata <= '0;
			endcase
		end
		else
			reg_rdata <= '0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_lin_active_cond: assert property ( // R1
		lin_active[0] |-> $past(state_r == ST_NORM && !stb[0] && !sync2_r.bat_uv))
		else $error("LIN channel active outside its allowed condition");

	a_rxd_recessive: assert property ( // R2
		!lin_active[1] |=> lin_rxd[1])
		else $error("Inactive LIN receive output not recessive");

	a_tx_timeout_off: assert property ( // R7
		tx_off_r[0] |=> !lin_tx_dom[0])
		else $error("Transmitter still dominant after time-out");

	a_tx_rise_reset: assert property ( // R8
		sync2_r.txd[0] |=> tx_cnt_r[0] == 24'h000000 && !tx_off_r[0])
		else $error("Dominant timer not reset by high transmit input");

	a_sleep_wake_exit: assert property ( // R11
		state_r == ST_SLEEP && any_wake |=> state_r == ST_STBY ##0 mode_r == MODE_STBY)
		else $error("Wake in sleep did not reach standby");

	a_irq_pin_level: assert property ( // R15
		|stat_r |=> irq_out_n_oe)
		else $error("Interrupt line released while status pends");

	a_w1c_clear: assert property ( // R16
		stat_wr && reg_wdata[IRQ_CYCLIC] && !stat_set[IRQ_CYCLIC] |=> !stat_r[IRQ_CYCLIC])
		else $error("Status bit survived a write of one");

	a_w1c_keep: assert property ( // R16
		stat_wr && !reg_wdata[IRQ_CAN_WAKE] && stat_r[IRQ_CAN_WAKE] |=> stat_r[IRQ_CAN_WAKE])
		else $error("Status bit cleared without a write of one");

	a_pend_keep: assert property ( // R17
		state_r == ST_STBY && pend_r[0] && stat_wr |=> pend_r[0])
		else $error("Pending wake lost on status clear");

	a_pend_clear: assert property ( // R18
		state_r == ST_NORM && !stb[1] && !lin_wake_hit[1] |=> !pend_r[1])
		else $error("Pending wake not cleared in normal mode");

	a_ot_entry: assert property ( // R21
		awake && sync2_r.ot |=> state_r == ST_OT ##1 system_reset_out_n_oe && limp_home && !v1_en)
		else $error("Overtemp entry or its outputs wrong");

	a_ot_exit: assert property ( // R22
		state_r == ST_OT && !sync2_r.ot |=> state_r == ST_STBY)
		else $error("Overtemp exit did not reach standby");

	a_v2_supply: assert property ( // R24
		v2_en |-> $past(state_r == ST_NORM && mode_r == MODE_NORM_V2ON))
		else $error("CAN supply on outside mode eleven");

	c_lin_wake: cover property (lin_lowpower[0] && lin_wake_hit[0]);
	c_tx_timeout: cover property ($rose(tx_off_r[1]));
	c_ot_cycle: cover property (state_r == ST_OT ##[1:50] state_r == ST_STBY);
	c_cyclic_irq: cover property (stat_set[IRQ_CYCLIC]);

endmodule : lwc_core

// ### lwc_core_tb.sv
`timescale 1ns/1ps
module lwc_core_tb;
	import lwc_pkg::*;
	localparam int TO = 50;
	localparam int MS = 10;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	lwc_pins_t         pv = PINS_RST;
	lwc_pins_t         pins_in;
	logic              wd_timeout_mode = 1'b0;
	logic              wd_overflow = 1'b0;
	logic [1:0]        lin_rxd, lin_tx_dom, lin_active, lin_lowpower, bus_dom, txd;
	logic [1:0]        force_dom = 2'h0;
	logic [1:0]        tx_en = 2'h0;
	logic [1:0]        tx_val = 2'h3;
	logic              can_tx_en, v1_en, v2_en, limp_home, wake_bias_out, irq_oe, rst_oe;
	logic              irq_o, rst_o;
	int                err_total = 0;
	int                total_checks = 0;
	int                n;

	always #5 clk = ~clk;

	always_comb
	begin
		pins_in         = pv;
		pins_in.lin_dom = bus_dom;
		pins_in.txd     = txd;
	end

	lwc_lin_host i_lwc_lin_host (.tx_dom(lin_tx_dom), .force_dom(force_dom), .tx_en(tx_en),
		.tx_val(tx_val), .lin_dom(bus_dom), .txd(txd));

	lwc_core #(.TX_TO_CYCLES(TO), .MS_CYCLES(MS)) i_lwc_core (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pins_in(pins_in), .wd_timeout_mode(wd_timeout_mode),
		.wd_overflow(wd_overflow), .lin_rxd(lin_rxd), .lin_tx_dom(lin_tx_dom),
		.lin_active(lin_active), .lin_lowpower(lin_lowpower), .can_tx_en(can_tx_en),
		.v1_en(v1_en), .v2_en(v2_en), .limp_home(limp_home), .wake_bias_out(wake_bias_out),
		.irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe), .system_reset_out_n_o(rst_o),
		.system_reset_out_n_oe(rst_oe));

	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : wt

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rchk(input string s, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(s, reg_rdata & m, e);
	endtask : rchk

	// Rise-to-rise count of the bias output, bounded so a dead output cannot hang.
	task automatic per(output int c);
		int i;
		for (i = 0; i < 2000 && wake_bias_out !== 1'b0; i++) wt(1);
		for (i = 0; i < 2000 && wake_bias_out !== 1'b1; i++) wt(1);
		for (c = 0; c < 2000 && wake_bias_out !== 1'b0; c++) wt(1);
		for (c = c; c < 2000 && wake_bias_out !== 1'b1; c++) wt(1);
		if (c >= 2000)
		begin
			err_total++;
			end_sim();
		end
	endtask : per

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wt(3);
		chk("v1", v1_en, 1);
		chk("rxd", lin_rxd, 2'h3);
		chk("irq", irq_oe, 0);
		rchk("mode", MODE_CTRL_OFS, 16'hFFFF, MODE_CTRL_RST);
		rchk("ictl", INT_CTRL_OFS, 16'hFFFF, INT_CTRL_RST);
		rchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
		wr(MODE_CTRL_OFS, 16'(MODE_NORM_V2OFF));
		wt(3);
		chk("act", lin_active, 2'h3);
		chk("v2off", v2_en, 0);
		wr(MODE_CTRL_OFS, 16'(MODE_NORM_V2ON));
		wt(3);
		chk("v2on", v2_en, 1);
		chk("canon", can_tx_en, 1);
		chk("txfloat", lin_tx_dom, 2'h0);
		@(posedge clk);
		tx_en  <= 2'h3;
		tx_val <= 2'h2;
		wt(8);
		chk("txdom", lin_tx_dom, 2'h1);
		chk("rxdom", lin_rxd, 2'h2);
		wt(25);
		tx_val <= 2'h3;
		wt(3);
		tx_val <= 2'h2;
		wt(30);
		chk("txrestart", lin_tx_dom, 2'h1);
		wt(30);
		chk("txto", lin_tx_dom, 2'h0);
		chk("rxrel", lin_rxd, 2'h3);
		tx_en     <= 2'h0;
		pv.bat_uv <= 1'b1;
		wt(6);
		chk("uv", lin_active, 2'h0);
		pv.bat_uv <= 1'b0;
		wr(INT_CTRL_OFS, 16'h0004);
		wt(3);
		chk("act1", lin_active, 2'h1);
		chk("lp1", lin_lowpower, 2'h2);
		wr(MODE_CTRL_OFS, 16'(MODE_STBY));
		wt(3);
		chk("off", lin_active, 2'h0);
		chk("lp2", lin_lowpower, 2'h2);
		wr(INT_CTRL_OFS, 16'h0006);
		force_dom <= 2'h1;
		wt(1000);
		force_dom <= 2'h0;
		wt(5);
		rchk("short", INT_STAT_OFS, 16'h0001, 16'h0000);
		force_dom <= 2'h1;
		wt(LIN_WAKE_CYC + 20);
		force_dom <= 2'h0;
		wt(3);
		rchk("lwake", INT_STAT_OFS, 16'h0001, 16'h0001);
		chk("irqon", irq_oe, 1);
		chk("irqpin", irq_o, 0);
		wr(INT_STAT_OFS, 16'h0002);
		rchk("w1c0", INT_STAT_OFS, 16'h0001, 16'h0001);
		wr(INT_STAT_OFS, 16'h0001);
		wt(2);
		rchk("w1c", INT_STAT_OFS, 16'h003F, 16'h0000);
		chk("irqoff", irq_oe, 0);
		rchk("pend", WD_STATE_OFS, 16'h0400, 16'h0400);
		// The bus wake flag must outlive a clear aimed at another bit.
		wr(INT_CTRL_OFS, 16'h0007);
		pv.can_wake <= 1'b1;
		wt(4);
		wr(INT_STAT_OFS, 16'h0001);
		rchk("ckeep", INT_STAT_OFS, 16'h0004, 16'h0004);
		wr(INT_STAT_OFS, 16'h0004);
		pv.can_wake <= 1'b0;
		rchk("cclr", INT_STAT_OFS, 16'h0004, 16'h0000);
		rchk("cpend", WD_STATE_OFS, 16'h1000, 16'h1000);
		wr(INT_CTRL_OFS, 16'h0004);
		wr(MODE_CTRL_OFS, 16'(MODE_NORM_V2OFF));
		wt(3);
		rchk("pendclr", WD_STATE_OFS, 16'h1C00, 16'h0000);
		for (int p = 0; p < 2; p++)
		begin
			for (int c = 0; c < 4; c++)
			begin
				wr(INT_CTRL_OFS, 16'(c) << (p ? SECOND_WAKE_EDGE_CFG_LSB : FIRST_WAKE_EDGE_CFG_LSB));
				wr(INT_STAT_OFS, 16'h003F);
				pv.wake_pin[p] <= 1'b1;
				wt(6);
				rchk("rise", INT_STAT_OFS, 16'h0018,
					16'(c == WIC_RISE || c == WIC_BOTH) << (IRQ_PIN1_WAKE + p));
				rchk("lvl", WD_STATE_OFS, 16'h0008 << p, 16'(c != WIC_OFF) << (3 + p));
				wr(INT_STAT_OFS, 16'h003F);
				pv.wake_pin[p] <= 1'b0;
				wt(6);
				rchk("fall", INT_STAT_OFS, 16'h0018,
					16'(c == WIC_FALL || c == WIC_BOTH) << (IRQ_PIN1_WAKE + p));
			end
		end
		wr(INT_CTRL_OFS, 16'(WIC_BOTH) << FIRST_WAKE_EDGE_CFG_LSB);
		wr(MODE_CTRL_OFS, 16'(MODE_SLEEP));
		wt(3);
		chk("v1sleep", v1_en, 0);
		pv.wake_pin[0] <= 1'b1;
		wt(8);
		rchk("wakeup", WD_STATE_OFS, 16'h0003, 16'(MODE_STBY));
		chk("v1stby", v1_en, 1);
		wr(INT_CTRL_OFS, (16'h0001 << FIRST_WAKE_SAMPLE_ENABLE_BIT) | (16'(WIC_BOTH) << FIRST_WAKE_EDGE_CFG_LSB));
		wr(MODE_CTRL_OFS, 16'(MODE_STBY));
		pv.wake_pin[0] <= 1'b0;
		wt(3);
		wr(INT_STAT_OFS, 16'h003F);
		per(n);
		chk("p16", 16'(n), 16'(BIAS_SHORT_MS * MS));
		wt(15);
		// The first bias samples of the low pin leave a falling-edge flag behind.
		wr(INT_STAT_OFS, 16'h003F);
		pv.wake_pin[0] <= 1'b1;
		wt(5);
		pv.wake_pin[0] <= 1'b0;
		wt(5);
		rchk("nosamp", INT_STAT_OFS, 16'h0008, 16'h0000);
		pv.wake_pin[0] <= 1'b1;
		wt(170);
		rchk("samp", INT_STAT_OFS, 16'h0008, 16'h0008);
		wr(MODE_CTRL_OFS, 16'h0001 << BIAS_SEL_BIT);
		per(n);
		chk("p64", 16'(n), 16'(BIAS_LONG_MS * MS));
		wr(INT_CTRL_OFS, 16'h0000);
		wr(MODE_CTRL_OFS, 16'(MODE_NORM_V2ON));
		wr(INT_STAT_OFS, 16'h003F);
		wd_timeout_mode <= 1'b1;
		wt(3);
		rchk("cien", WD_STATE_OFS, 16'h0004, 16'h0004);
		wd_overflow <= 1'b1;
		wt(1);
		wd_overflow <= 1'b0;
		wt(2);
		rchk("ci", INT_STAT_OFS, 16'h0020, 16'h0020);
		pv.wd_off <= 1'b1;
		wt(4);
		rchk("cioff", WD_STATE_OFS, 16'h0004, 16'h0000);
		wd_timeout_mode <= 1'b0;
		tx_en           <= 2'h3;
		tx_val          <= 2'h0;
		wt(6);
		chk("txboth", lin_tx_dom, 2'h3);
		pv.ot <= 1'b1;
		wt(6);
		chk("rstlow", rst_oe, 1);
		chk("rstpin", rst_o, 0);
		chk("limp", limp_home, 1);
		chk("regs", {v1_en, v2_en, can_tx_en}, 0);
		chk("txoff", lin_tx_dom, 2'h0);
		pv.ot <= 1'b0;
		wt(6);
		rchk("otexit", WD_STATE_OFS, 16'h0023, 16'(MODE_STBY));
		chk("rstrel", rst_oe, 0);
		chk("v1back", v1_en, 1);
		end_sim();
	end
endmodule : lwc_core_tb

// ### lwc_lin_host.sv
`timescale 1ns/1ps
module lwc_lin_host (
	input  wire logic [1:0] tx_dom,
	input  wire logic [1:0] force_dom,
	input  wire logic [1:0] tx_en,
	input  wire logic [1:0] tx_val,
	output logic      [1:0] lin_dom,
	output logic      [1:0] txd
);
	// The bus is wired, so any node pulling it makes it dominant.
	assign lin_dom = tx_dom | force_dom;
	assign txd = (tx_en & tx_val) | ~tx_en;
endmodule : lwc_lin_host

// ### lwc_pkg.sv
package lwc_pkg;

	localparam int CLK_MHZ = 100;

	// Register bus geometry.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register offsets.
	localparam logic [ADDR_W-1:0] MODE_CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] INT_CTRL_OFS  = 4'h1;
	localparam logic [ADDR_W-1:0] INT_STAT_OFS  = 4'h2;
	localparam logic [ADDR_W-1:0] WD_STATE_OFS  = 4'h3;

	// Mode control fields.
	localparam int MODE_LSB = 0;
	localparam int BIAS_SEL_BIT = 2;

	// Interrupt control fields.
	localparam int CAN_STB_BIT = 0;
	localparam int LIN1_STB_BIT = 1;
	localparam int LIN2_STB_BIT = 2;
	localparam int FIRST_WAKE_EDGE_CFG_LSB = 3;
	localparam int SECOND_WAKE_EDGE_CFG_LSB = 5;
	localparam int FIRST_WAKE_SAMPLE_ENABLE_BIT = 7;
	localparam int SECOND_WAKE_SAMPLE_ENABLE_BIT = 8;

	// Interrupt status bits.
	localparam int IRQ_LIN1_WAKE = 0;
	localparam int IRQ_LIN2_WAKE = 1;
	localparam int IRQ_CAN_WAKE = 2;
	localparam int IRQ_PIN1_WAKE = 3;
	localparam int IRQ_PIN2_WAKE = 4;
	localparam int IRQ_CYCLIC = 5;
	localparam int IRQ_N = 6;

	// Operating mode field values.
	localparam logic [1:0] MODE_STBY = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_NORM_V2OFF = 2'h2;
	localparam logic [1:0] MODE_NORM_V2ON = 2'h3;

	// Wake edge configuration values.
	localparam logic [1:0] WIC_OFF = 2'h0;
	localparam logic [1:0] WIC_FALL = 2'h1;
	localparam logic [1:0] WIC_RISE = 2'h2;
	localparam logic [1:0] WIC_BOTH = 2'h3;

	// Reset values.
	localparam logic [DATA_W-1:0] MODE_CTRL_RST = 16'h0000;
	localparam logic [DATA_W-1:0] INT_CTRL_RST = 16'h0000;

	// Timing.
	localparam int LIN_WAKE_DOM_US = 30;
	localparam int LIN_WAKE_CYC = LIN_WAKE_DOM_US * CLK_MHZ;
	localparam int TX_DOM_TO_US = 20000;
	localparam int TX_DOM_TO_CYC = TX_DOM_TO_US * CLK_MHZ;
	localparam int MS_US = 1000;
	localparam int MS_CYC = MS_US * CLK_MHZ;
	localparam int BIAS_SHORT_MS = 16;
	localparam int BIAS_LONG_MS = 64;
	localparam int BIAS_ON_MS = 1;

	typedef enum logic [3:0] {
		ST_STBY  = 4'h1,
		ST_SLEEP = 4'h2,
		ST_NORM  = 4'h4,
		ST_OT    = 4'h8
	} lwc_state_t;

	typedef struct packed {
		logic       ot;
		logic       bat_uv;
		logic [1:0] lin_dom;
		logic       can_wake;
		logic [1:0] wake_pin;
		logic       wd_off;
		logic [1:0] txd;
	} lwc_pins_t;

	localparam lwc_pins_t PINS_RST = '{ot: 1'b0, bat_uv: 1'b0, lin_dom: 2'h0, can_wake: 1'b0,
		wake_pin: 2'h0, wd_off: 1'b0, txd: 2'h3};

endpackage : lwc_pkg
